// file: common/tsw_pkg.sv
// Purpose: Constants for the time-slot switch frame adapter.
// Assumes: Switch bit clock is twice the data bit rate.
// Notes:   Channel numbers follow the internal 32-channel numbering.
package tsw_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int NUM_CHANNELS      = 32;
  localparam int CHAN_BITS         = 8;
  localparam int NA_CHANNELS       = 24;
  localparam int NA_FRAME_BITS     = NA_CHANNELS * CHAN_BITS + 1;
  localparam int NA_LAST_IN_CHAN   = 31;
  localparam int NA_OUT_CHAN_ZERO  = 24;
  localparam int IF_CHANNELS       = 2;
  localparam int FROZEN_PERIODS    = 2;
  localparam int MAX_RATE_KBPS     = 2048;
  localparam int SYNC_MIN_DIV      = 16;
  localparam int SYNC_MAX_DIV      = 256;

  // ----------------------------------------------------------------
  // Modes and instructions
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_STD   = 3'h1,
    MODE_NA    = 3'h2,
    MODE_IFACE = 3'h4
  } tsw_mode_type;

  localparam logic [2:0] INSTR_CONNECT = 3'h1;
  localparam logic [2:0] INSTR_READ    = 3'h3;
  localparam logic [2:0] INSTR_FORCE   = 3'h4;

  typedef enum logic [2:0] {
    CMD_IDLE  = 3'h1,
    CMD_APPLY = 3'h2,
    CMD_DONE  = 3'h4
  } tsw_cmd_state_type;

endpackage

// file: common/tsw_slot_if.sv
// Purpose: Slot events passed from the link domain to the core domain.
// Assumes: Word carries one finished channel and its number.
// Notes:   Toggle plus stable word crossing.
`timescale 1ns/100ps
interface tsw_slot_if #(parameter int STREAMS = 8);
  logic                          slot_tgl;
  logic [4:0]                    slot_chan;
  logic [STREAMS*8-1:0]          slot_data;
  logic [4:0]                    out_chan;
  logic [STREAMS*8-1:0]          out_data;
  modport link (output slot_tgl, output slot_chan, output slot_data,
                output out_chan, input out_data);
  modport core (input slot_tgl, input slot_chan, input slot_data,
                input out_chan, output out_data);
endinterface

// file: design/tsw_link_side.sv
// Purpose: Link-clock side: bit counting, shifting, output serialising.
// Assumes: Frame sync is sampled by the link clock.
// Notes:   Inputs are sampled in the second half of each bit time.
`timescale 1ns/100ps
module tsw_link_side
  import tsw_pkg::*;
#(
  parameter int STREAMS = 8
) (
  input  wire logic               switch_bit_clock,
  input  wire logic               rst_b,
  input  wire logic [1:0]         mode_sel,
  input  wire logic               frame_sync,
  input  wire logic [STREAMS-1:0] stream_in,
  output logic [STREAMS-1:0]      stream_out,
  tsw_slot_if.link                slot
);
  logic [7:0]           bit_cnt_reg, bit_cnt_next;
  logic                 half_reg, half_next;
  logic                 sync_d_reg;
  logic [STREAMS*8-1:0] shift_reg, shift_next;
  logic [STREAMS*8-1:0] oshift_reg, oshift_next;
  logic [STREAMS-1:0]   ch0b0_reg, ch0b0_next;
  logic [STREAMS-1:0]   out_reg, out_next;
  logic                 tgl_reg, tgl_next;
  logic [4:0]           chan_reg, chan_next;
  logic [STREAMS*8-1:0] data_reg, data_next;
  logic                 na_mode;
  logic                 sync_rise;
  logic [7:0]           cnt_eff;
  logic                 half_eff;
  logic [4:0]           cur_chan;
  logic [4:0]           in_chan;
  logic                 aux_bit;

  assign na_mode   = (mode_sel == 2'h1);
  assign sync_rise = frame_sync && !sync_d_reg;
  // Sync rising edge restarts the count at this very edge.
  assign cnt_eff   = sync_rise ? 8'h00 : bit_cnt_reg;
  assign half_eff  = sync_rise ? 1'b0 : half_reg;
  assign cur_chan  = cnt_eff[7:3];
  // Auxiliary bit closes a frame of 193 bit times.
  assign aux_bit   = na_mode && (cnt_eff == 8'(NA_FRAME_BITS - 1));
  // Last input channel is stored under channel 31.
  assign in_chan   = (na_mode && cur_chan == 5'(NA_CHANNELS - 1)) ?
                     5'(NA_LAST_IN_CHAN) : cur_chan;

  always_comb begin
    bit_cnt_next = cnt_eff;
    half_next    = ~half_eff;
    shift_next   = shift_reg;
    oshift_next  = oshift_reg;
    ch0b0_next   = ch0b0_reg;
    out_next     = out_reg;
    tgl_next     = tgl_reg;
    chan_next    = chan_reg;
    data_next    = data_reg;
    if (half_eff) begin
      bit_cnt_next = cnt_eff + 8'h01;
      if (!aux_bit) begin
        // Second half of bit time gives margin for skewed flows.
        for (int s = 0; s < STREAMS; s++) begin
          shift_next[s*8 +: 8] = {shift_reg[s*8 +: 7], stream_in[s]};
        end
        if (cnt_eff[2:0] == 3'h7) begin
          // Finished slot goes to memory at the preceding channel.
          tgl_next  = ~tgl_reg;
          chan_next = in_chan;
          data_next = shift_next;
        end
      end
      if (na_mode && cnt_eff == 8'(NA_FRAME_BITS - 2)) begin
        // Output held over the frozen auxiliary bit copies bit 0.
        out_next = ch0b0_reg;
      end
    end else if (!aux_bit) begin
      if (cnt_eff[2:0] == 3'h0) begin
        oshift_next = slot.out_data;
      end
      for (int s = 0; s < STREAMS; s++) begin
        out_next[s] = oshift_next[s*8 + 7 - int'(cnt_eff[2:0])];
      end
      if (cur_chan == 5'h00 && cnt_eff[2:0] == 3'h0) begin
        ch0b0_next = out_next;
      end
    end
  end

  always_ff @(posedge switch_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= 8'h00;
      half_reg    <= 1'b0;
      sync_d_reg  <= 1'b0;
      shift_reg   <= '0;
      oshift_reg  <= '0;
      ch0b0_reg   <= '0;
      out_reg     <= '0;
      tgl_reg     <= 1'b0;
      chan_reg    <= 5'h00;
      data_reg    <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      half_reg    <= half_next;
      sync_d_reg  <= frame_sync;
      shift_reg   <= shift_next;
      oshift_reg  <= oshift_next;
      ch0b0_reg   <= ch0b0_next;
      out_reg     <= out_next;
      tgl_reg     <= tgl_next;
      chan_reg    <= chan_next;
      data_reg    <= data_next;
    end
  end

  assign stream_out     = out_reg;
  assign slot.slot_tgl  = tgl_reg;
  assign slot.slot_chan = chan_reg;
  assign slot.slot_data = data_reg;
  // Output channel zero is drawn from channel 24 in 193-bit frames.
  assign slot.out_chan  = (na_mode && cur_chan == 5'h00) ?
                          5'(NA_OUT_CHAN_ZERO) : cur_chan;

  a_aux_copy: assert property (@(posedge switch_bit_clock)
    disable iff (!rst_b)
    (na_mode && half_eff && cnt_eff == 8'(NA_FRAME_BITS - 2))
    |=> (stream_out == $past(ch0b0_reg)))
    else $error("Auxiliary bit does not copy channel zero bit zero.");
  a_slot_event: assert property (@(posedge switch_bit_clock)
    disable iff (!rst_b) $changed(tgl_reg) |-> (chan_reg == $past(in_chan)))
    else $error("Slot event channel mismatch.");
  a_sync_restart: assert property (@(posedge switch_bit_clock)
    disable iff (!rst_b) sync_rise |=> (bit_cnt_reg == 8'h00 && half_reg))
    else $error("Frame sync did not restart the bit count.");
endmodule

// file: design/tsw_frame_adapter.sv
// Purpose: Time-slot switch with frame adaptation for three modes.
// Assumes: Connections arrive on a simple command port in core clock.
// Notes:   Link logic runs on the switch bit clock.
`timescale 1ns/100ps

// Operation
// - Auxiliary mode frame is 193 bit times.
// - Auxiliary bit ignored, output copies channel zero bit.
// - Data rate up to 2048k, clock twice rate.
// - Skewed input flows accepted without equalisation.
// - Interface mode sync is sampling strobe.
// - One input and output stream per interface.
// - Instructions three and four read or force.
// - Slot bits stored at the preceding channel.
module tsw_frame_adapter
  import tsw_pkg::*;
#(
  parameter int STREAMS = 8
) (
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  input  wire logic               switch_bit_clock,
  input  wire logic [1:0]         mode_sel,
  input  wire logic               frame_sync,
  input  wire logic [STREAMS-1:0] stream_in,
  output logic [STREAMS-1:0]      stream_out,
  input  wire logic               cmd_valid,
  input  wire logic [2:0]         cmd_instr,
  input  wire logic [7:0]         cmd_in_addr,
  input  wire logic [7:0]         cmd_out_addr,
  input  wire logic [7:0]         cmd_data,
  output logic                    cmd_ready,
  output logic                    rd_valid,
  output logic [7:0]              rd_data
);
  localparam int ADDR_W = $clog2(STREAMS) + 5;

  tsw_slot_if #(.STREAMS(STREAMS)) slot ();

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  // One stream pair per interface in interface mode.
  tsw_link_side #(.STREAMS(STREAMS)) u_link (
    .switch_bit_clock (switch_bit_clock),
    .rst_b            (rst_b),
    .mode_sel         (mode_sel),
    .frame_sync       (frame_sync),
    .stream_in        (stream_in),
    .stream_out       (stream_out),
    .slot             (slot)
  );

  // ----------------------------------------------------------------
  // Crossing of slot events
  // ----------------------------------------------------------------
  logic [2:0] tgl_sync_reg;
  logic       tgl_seen_reg;
  logic       slot_evt;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_sync_reg <= 3'h0;
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], slot.slot_tgl};
      if (tgl_sync_reg[2] == tgl_sync_reg[1]) begin
        tgl_seen_reg <= tgl_sync_reg[2];
      end
    end
  end
  assign slot_evt = (tgl_sync_reg[2] == tgl_sync_reg[1])
                    && (tgl_sync_reg[2] != tgl_seen_reg);

  // ----------------------------------------------------------------
  // Speech memory and connection memory
  // ----------------------------------------------------------------
  logic [7:0]        speech_memory [STREAMS*NUM_CHANNELS];
  logic [ADDR_W:0]   conn_mem      [STREAMS*NUM_CHANNELS];
  logic [7:0]        force_mem     [STREAMS*NUM_CHANNELS];
  logic [4:0]        wr_chan;
  tsw_cmd_state_type state_reg, state_next;
  logic              rd_valid_next;
  logic [7:0]        rd_data_next;

  // Stored at the channel before the one now shifting.
  assign wr_chan = slot.slot_chan;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STREAMS*NUM_CHANNELS; i++) begin
        speech_memory[i] <= 8'h00;
        conn_mem[i]      <= '0;
        force_mem[i]     <= 8'h00;
      end
    end else begin
      if (slot_evt) begin
        for (int s = 0; s < STREAMS; s++) begin
          speech_memory[s*NUM_CHANNELS + int'(wr_chan)] <=
            slot.slot_data[s*8 +: 8];
        end
      end
      if (state_reg == CMD_APPLY) begin
        if (cmd_instr == INSTR_CONNECT) begin
          conn_mem[cmd_out_addr[ADDR_W-1:0]] <=
            {1'b1, cmd_in_addr[ADDR_W-1:0]};
        end else if (cmd_instr == INSTR_FORCE) begin
          // Forcing loads a constant byte on the output channel.
          conn_mem[cmd_out_addr[ADDR_W-1:0]]  <= '0;
          force_mem[cmd_out_addr[ADDR_W-1:0]] <= cmd_data;
        end
      end
    end
  end

  // Output word for the current slot, in internal numbering.
  always_comb begin
    slot.out_data = '0;
    for (int s = 0; s < STREAMS; s++) begin
      if (conn_mem[s*NUM_CHANNELS + int'(slot.out_chan)][ADDR_W]) begin
        slot.out_data[s*8 +: 8] = speech_memory[int'(
          conn_mem[s*NUM_CHANNELS + int'(slot.out_chan)][ADDR_W-1:0])];
      end else begin
        slot.out_data[s*8 +: 8] =
          force_mem[s*NUM_CHANNELS + int'(slot.out_chan)];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command port
  // ----------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    rd_valid_next = 1'b0;
    rd_data_next  = rd_data;
    case (state_reg)
      CMD_IDLE: begin
        if (cmd_valid) begin
          state_next = CMD_APPLY;
        end
      end
      CMD_APPLY: begin
        if (cmd_instr == INSTR_READ) begin
          // Reading returns the speech memory byte at the input address.
          rd_valid_next = 1'b1;
          rd_data_next  = speech_memory[cmd_in_addr[ADDR_W-1:0]];
        end
        state_next = CMD_DONE;
      end
      CMD_DONE: begin
        state_next = CMD_IDLE;
      end
      default: begin
        state_next = CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= CMD_IDLE;
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
    end else begin
      state_reg <= state_next;
      rd_valid  <= rd_valid_next;
      rd_data   <= rd_data_next;
    end
  end

  assign cmd_ready = (state_reg == CMD_IDLE);

  a_read_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_reg == CMD_APPLY && cmd_instr == INSTR_READ) |=> rd_valid)
    else $error("Read instruction gave no answer.");
  a_cmd_seq: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cmd_ready && cmd_valid) |=> !cmd_ready ##1 !cmd_ready ##1 cmd_ready)
    else $error("Command sequence timing wrong.");
  a_store_slot: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    slot_evt |=> (speech_memory[$past(wr_chan)]
                  == $past(slot.slot_data[7:0])))
    else $error("Slot byte not stored in speech memory.");
endmodule

// file: bench/tsw_link_partner.sv
// Purpose: Link-side partner that makes the bit clock, sync and streams.
// Assumes: Bits go MSB first, two clock periods per bit; no clock in the auxiliary bit.
// Notes:   Captures stream_out after the first clock of each bit time, at the end of the auxiliary bit.
`timescale 1ns/100ps
module tsw_link_partner
  import tsw_pkg::*;
(
  output logic            switch_bit_clock,
  output logic            frame_sync,
  output logic [7:0]      stream_in,
  input  wire logic [7:0] stream_out,
  input  wire logic [1:0] mode_sel,
  input  wire logic       iface,
  input  wire logic [7:0] in_byte [8][32],
  output logic [255:0]    cap [8]
);
  int nbits;
  int b;
  int s;
  initial begin
    switch_bit_clock = 1'b0;
    frame_sync = 1'b0;
    stream_in = 8'h00;
    forever begin
      nbits = (mode_sel == 2'h1) ? NA_FRAME_BITS :
              iface ? IF_CHANNELS * CHAN_BITS :
              NUM_CHANNELS * CHAN_BITS;
      for (b = 0; b < nbits; b++) begin
        frame_sync = (b == 0);
        if (mode_sel == 2'h1 && b == NA_FRAME_BITS - 1) begin
          stream_in = ~stream_in;
          #125 frame_sync = 1'b1;
          #125;
          for (s = 0; s < 8; s++) cap[s][b] = stream_out[s];
        end else begin
          for (s = 0; s < 8; s++) stream_in[s] = in_byte[s][b/8][7-b%8];
          #62.5 switch_bit_clock = 1'b1;
          #62.5 switch_bit_clock = 1'b0;
          for (s = 0; s < 8; s++) cap[s][b] = stream_out[s];
          #62.5 switch_bit_clock = 1'b1;
          #62.5 switch_bit_clock = 1'b0;
        end
      end
    end
  end
endmodule

// file: bench/tsw_frame_adapter_test.sv
// Purpose: Self-checking bench for the frame adapter.
// Assumes: Address is {stream, channel}; read returns speech memory.
// Notes:   Expected bytes come from a model of the connection map.
`timescale 1ns/100ps
module tsw_frame_adapter_test
  import tsw_pkg::*;
;
  logic         core_clk;
  logic         rst_b;
  logic         switch_bit_clock;
  logic         frame_sync;
  logic [1:0]   mode_sel;
  logic         iface;
  logic [7:0]   stream_in;
  logic [7:0]   stream_out;
  logic         cmd_valid;
  logic [2:0]   cmd_instr;
  logic [7:0]   cmd_in_addr;
  logic [7:0]   cmd_out_addr;
  logic [7:0]   cmd_data;
  logic         cmd_ready;
  logic         rd_valid;
  logic [7:0]   rd_data;
  logic [7:0]   in_byte [8][32];
  logic [255:0] cap [8];
  logic [7:0]   exp_out [8][32];
  bit           used [8][32];
  int           error_cnt;
  int           checks;
  logic [31:0]  rng;
  int           i;

  tsw_frame_adapter #(.STREAMS(8)) tsw_frame_adapter_inst (.core_clk,
    .rst_b, .switch_bit_clock, .mode_sel, .frame_sync, .stream_in,
    .stream_out, .cmd_valid, .cmd_instr, .cmd_in_addr, .cmd_out_addr,
    .cmd_data, .cmd_ready, .rd_valid, .rd_data);
  tsw_link_partner tsw_link_partner_inst (.switch_bit_clock, .frame_sync,
    .stream_in, .stream_out, .mode_sel, .iface, .in_byte, .cap);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk8(input string n, input logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmd(input logic [2:0] c, input logic [7:0] a, o, d);
    int n;
    n = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_instr <= c;
    cmd_in_addr <= a;
    cmd_out_addr <= o;
    cmd_data <= d;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk1("cmd_ready", 1'b1, cmd_ready);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cmd(INSTR_READ, a, 8'h00, 8'h00);
    #1 chk1("rd_valid", 1'b0, rd_valid);
    @(posedge core_clk);
    #1 chk1("rd_valid", 1'b1, rd_valid);
    chk8("rd_data", e, rd_data);
  endtask

  task automatic con(input int s, input int c, input int o, input int k);
    bit na;
    na = (mode_sel == 2'h1);
    cmd(INSTR_CONNECT, {s[2:0], c[4:0]}, {o[2:0], k[4:0]}, 8'h00);
    if (na && k == NA_OUT_CHAN_ZERO) k = 0;
    if (na && c == NA_LAST_IN_CHAN) c = NA_CHANNELS - 1;
    exp_out[o][k] = in_byte[s][c];
    used[o][k] = 1'b1;
  endtask

  task automatic wait_check();
    logic [7:0] g;
    repeat (4) @(posedge frame_sync);
    if (mode_sel == 2'h1) begin
      for (int o = 0; o < 8; o++) begin
        if (used[o][0]) chk1("aux_bit", exp_out[o][0][7], cap[o][192]);
      end
    end
    for (int o = 0; o < 8; o++) for (int k = 0; k < 32; k++) begin
      for (int j = 0; j < 8; j++) g[7-j] = cap[o][8*k+j];
      if (used[o][k]) chk8("stream_out", exp_out[o][k], g);
      used[o][k] = 1'b0;
    end
  endtask

  initial begin
    rng = 32'h3CC7;
    error_cnt = 0;
    checks = 0;
    rst_b = 1'b0;
    mode_sel = 2'h0;
    iface = 1'b0;
    cmd_valid = 1'b0;
    cmd_instr = 3'h0;
    cmd_in_addr = 8'h00;
    cmd_out_addr = 8'h00;
    cmd_data = 8'h00;
    for (int s = 0; s < 8; s++) for (int c = 0; c < 32; c++) begin
      rng = xs(rng);
      in_byte[s][c] = rng[7:0];
      used[s][c] = 1'b0;
    end
    repeat (4) @(posedge switch_bit_clock);
    @(posedge core_clk);
    rst_b <= 1'b1;
    // ------------------------------------------------------------
    // Standard frames: random connections and a forced byte.
    // ------------------------------------------------------------
    for (i = 0; i < 4; i++) begin
      rng = xs(rng);
      con(rng[2:0], rng[12:8], i, rng[20:16]);
    end
    rng = xs(rng);
    cmd(INSTR_FORCE, 8'h00, {3'h4, rng[4:0]}, rng[15:8]);
    exp_out[4][rng[4:0]] = rng[15:8];
    used[4][rng[4:0]] = 1'b1;
    wait_check();
    for (i = 0; i < 2; i++) begin
      rng = xs(rng);
      rd({rng[2:0], rng[12:8]}, in_byte[rng[2:0]][rng[12:8]]);
    end
    // ------------------------------------------------------------
    // 193-bit frames with a frozen auxiliary bit.
    // ------------------------------------------------------------
    @(posedge core_clk);
    mode_sel <= 2'h1;
    repeat (2) @(posedge frame_sync);
    rng = xs(rng);
    con(rng[2:0], NA_LAST_IN_CHAN, 5, NA_OUT_CHAN_ZERO);
    con(rng[10:8], rng[20:16] % 23, 6, 1 + rng[28:24] % 23);
    wait_check();
    rd({3'h2, 5'h1F}, in_byte[2][NA_CHANNELS-1]);
    // ------------------------------------------------------------
    // Interface frames of two channels.
    // ------------------------------------------------------------
    @(posedge core_clk);
    mode_sel <= 2'h0;
    iface <= 1'b1;
    repeat (2) @(posedge frame_sync);
    for (i = 0; i < 4; i++) con(i/2*7, i%2, 7-i/2*7, i%2);
    wait_check();
    rd(8'h01, in_byte[0][1]);
    end_of_test();
  end

  initial begin
    #2000000;
    error_cnt++;
    end_of_test();
  end
endmodule
